/* design/tcrb_pkg.sv */
// Package for the transceiver configuration register bank.
// Assumes a byte-wide register port driven by an SPI front end outside this block.
package tcrb_pkg;

  // ==========================================================================
  // Address map
  localparam logic [7:0] TCRB_ADDR_ANA_CFG_HI   = 8'h00;
  localparam logic [7:0] TCRB_ADDR_STATUS       = 8'hC0;
  localparam logic [7:0] TCRB_ADDR_EVENTS       = 8'hC1;

  // ==========================================================================
  // Field layout of analog_function_config_high
  localparam int         TCRB_XO_DRIVE_LSB      = 2;
  localparam int         TCRB_XO_DRIVE_MSB      = 4;
  localparam int         TCRB_BATT_SEL_LSB      = 0;
  localparam int         TCRB_BATT_SEL_MSB      = 1;
  localparam logic [2:0] TCRB_RSV_RESET         = 3'h0;
  localparam logic [2:0] TCRB_XO_DRIVE_RESET    = 3'h3;
  localparam logic [1:0] TCRB_BATT_SEL_RESET    = 2'h0;
  localparam logic [7:0] TCRB_ANA_CFG_HI_RESET  = {TCRB_RSV_RESET, TCRB_XO_DRIVE_RESET,
                                                   TCRB_BATT_SEL_RESET};

  // Battery-low threshold encodings: 2.7 V, 2.5 V, 2.3 V, 2.1 V
  typedef enum logic [1:0] {
    TCRB_BATT_2V7 = 2'h0,
    TCRB_BATT_2V5 = 2'h1,
    TCRB_BATT_2V3 = 2'h2,
    TCRB_BATT_2V1 = 2'h3
  } tcrb_batt_level_type;

  localparam logic [7:0] TCRB_EVENTS_RESET      = 8'h00;
  localparam logic [7:0] TCRB_UNMAPPED_DATA     = 8'h00;

endpackage

/* design/tcrb_event_bit.sv */
// One read-and-clear event flag.
// Assumes read strobe and event are synchronous to clk_sys_i.
`timescale 1ns/1ps
module tcrb_event_bit
  import tcrb_pkg::*;
(
  input  wire logic clk_sys_i,   // System clock
  input  wire logic reset_n_i,   // Async reset, active low
  input  wire logic set_i,       // Event pulse
  input  wire logic clear_i,     // Clear after read
  output logic      flag_o       // Sticky flag
);

  logic flag_d;

  // Set wins over a clear in the same cycle
  assign flag_d = set_i | (flag_o & ~clear_i);  // [RL3]

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flag_o <= 1'b0;
    end else begin
      flag_o <= flag_d;
    end
  end

endmodule

/* design/tcrb_regbank.sv */
// Configuration register bank of a sub-GHz transceiver.
// Assumes an SPI slave front end presents one byte access per cycle strobe.
//
// Summary of operation
// RL1: Read-write registers return the last value written by the host.
// RL2: Read-only registers show internal state; host writes leave them unchanged.
// RL3: Read-and-clear registers return their value, then clear to zero after the read, except bits whose event arrives in the read cycle.
// RL4: Host keeps reserved fields at their reset values when writing.
// RL5: Address 0x00 bits 4:2 oscillator startup drive, reset 011; bits 7:5 reserved 000.
// RL6: Address 0x00 bits 1:0 battery-low threshold, reset 00, 2.7/2.5/2.3/2.1 V.
// RL7: Every field loads its reset value on device reset before any access.
`timescale 1ns/1ps
module tcrb_regbank
  import tcrb_pkg::*;
#(
  parameter int EVENT_W = 8                      // Number of read-and-clear event bits
)(
  input  wire logic               clk_sys_i,     // System clock, 40 MHz
  input  wire logic               reset_n_i,     // Async reset, active low
  input  wire logic [7:0]         addr_i,        // Register address
  input  wire logic               wr_en_i,       // Write strobe, one cycle
  input  wire logic [7:0]         wr_data_i,     // Write data
  input  wire logic               rd_en_i,       // Read strobe, one cycle
  input  wire logic [7:0]         status_i,      // Internal state for read-only register
  input  wire logic [EVENT_W-1:0] event_i,       // Event pulses for read-and-clear register
  output logic [7:0]              rd_data_o,     // Read data, valid cycle after rd_en_i
  output logic                    rd_valid_o,    // Read data valid pulse
  output logic [2:0]              xo_startup_drive_strength_o,  // Oscillator startup drive
  output logic [1:0]              battery_low_threshold_select_o // Detector threshold
);

  // ==========================================================================
  // Decode
  logic              hit_cfg;
  logic              hit_status;
  logic              hit_events;
  logic              wr_cfg;
  logic              clr_events;
  logic [7:0]        cfg_q;
  logic [7:0]        cfg_d;
  logic [EVENT_W-1:0] events_q;
  logic [7:0]        events_byte;
  logic [7:0]        rd_mux;

  assign hit_cfg    = (addr_i == TCRB_ADDR_ANA_CFG_HI);
  assign hit_status = (addr_i == TCRB_ADDR_STATUS);
  assign hit_events = (addr_i == TCRB_ADDR_EVENTS);
  assign wr_cfg     = wr_en_i & hit_cfg;                 // [RL1]
  assign clr_events = rd_en_i & hit_events;              // [RL3]
  // Reserved bits are held at reset value even if the host writes them
  assign cfg_d      = wr_cfg ? {TCRB_RSV_RESET, wr_data_i[4:0]} : cfg_q;  // [RL5]

  // ==========================================================================
  // Configuration register
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cfg_q <= TCRB_ANA_CFG_HI_RESET;                    // [RL7]
    end else begin
      cfg_q <= cfg_d;
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      xo_startup_drive_strength_o    <= TCRB_XO_DRIVE_RESET;   // [RL5]
      battery_low_threshold_select_o <= TCRB_BATT_SEL_RESET;   // [RL6]
    end else begin
      xo_startup_drive_strength_o    <= cfg_d[TCRB_XO_DRIVE_MSB:TCRB_XO_DRIVE_LSB]; // [RL5]
      battery_low_threshold_select_o <= cfg_d[TCRB_BATT_SEL_MSB:TCRB_BATT_SEL_LSB]; // [RL6]
    end
  end

  // ==========================================================================
  // Read-and-clear event bits
  for (genvar i = 0; i < EVENT_W; i++) begin : g_evt
    tcrb_event_bit u_bit (
      .clk_sys_i (clk_sys_i),
      .reset_n_i (reset_n_i),
      .set_i     (event_i[i]),
      .clear_i   (clr_events),
      .flag_o    (events_q[i])
    );
  end

  assign events_byte = 8'(events_q);

  // ==========================================================================
  // Read path; status register has no write path
  assign rd_mux = hit_cfg    ? cfg_q :                   // [RL1]
                  hit_status ? status_i :                // [RL2]
                  hit_events ? events_byte :             // [RL3]
                  TCRB_UNMAPPED_DATA;

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_data_o  <= 8'h00;
      rd_valid_o <= 1'b0;
    end else begin
      rd_data_o  <= rd_en_i ? rd_mux : rd_data_o;
      rd_valid_o <= rd_en_i;
    end
  end

  // ==========================================================================
  // Assertions
  sequence s_cfg_write;
    wr_en_i && hit_cfg;
  endsequence

  sequence s_cfg_read;
    rd_en_i && hit_cfg && !wr_en_i;
  endsequence

  AST_CFG_WRITE_READBACK: assert property (  // [RL1]
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    s_cfg_write ##1 s_cfg_read |=> rd_data_o == {3'h0, $past(wr_data_i[4:0], 2)})
    else $error("config readback mismatch");

  AST_RESERVED_ZERO: assert property (  // [RL5]
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    cfg_q[7:5] == TCRB_RSV_RESET)
    else $error("reserved bits changed");

  AST_DRIVE_OUT: assert property (  // [RL5]
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    xo_startup_drive_strength_o == cfg_q[4:2])
    else $error("drive output differs from register");

  AST_BATT_OUT: assert property (  // [RL6]
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    battery_low_threshold_select_o == cfg_q[1:0])
    else $error("threshold output differs from register");

  AST_STATUS_READ: assert property (  // [RL2]
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    rd_en_i && hit_status |=> rd_data_o == $past(status_i))
    else $error("status read mismatch");

  AST_STATUS_NO_WRITE: assert property (  // [RL2]
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    wr_en_i && hit_status |=> $stable(cfg_q))
    else $error("status write altered config");

  AST_EVENT_CLEAR: assert property (  // [RL3]
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    clr_events && !(|event_i) |=> events_q == '0)
    else $error("events not cleared after read");

  AST_EVENT_READ: assert property (  // [RL3]
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    clr_events |=> rd_data_o == 8'($past(events_q)) && rd_valid_o)
    else $error("event read lost value");

  AST_RESET_VALUE: assert property (  // [RL7]
    @(posedge clk_sys_i)
    $rose(reset_n_i) |-> cfg_q == TCRB_ANA_CFG_HI_RESET)
    else $error("config reset value wrong");

  // ==========================================================================
  // Access checks, multi-step and single-step
  // An idle cycle between write and read must not lose the written value
  sequence s_cfg_idle;
    !(wr_en_i && hit_cfg);
  endsequence

  sequence s_reset_release;
    $rose(reset_n_i);
  endsequence

  sequence s_evt_quiet_read;
    clr_events && !(|event_i);
  endsequence

  AST_CFG_READBACK_GAP: assert property (  // [RL1]
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    s_cfg_write ##1 s_cfg_idle ##1 s_cfg_read |=>
      rd_data_o == {TCRB_RSV_RESET, $past(wr_data_i[4:0], 3)})
    else $error("config readback after idle cycle mismatch");

  AST_CFG_WRITE: assert property (  // [RL1]
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    wr_cfg |=> cfg_q[4:0] == $past(wr_data_i[4:0]))
    else $error("config write not stored");

  AST_CFG_HOLD: assert property (  // [RL1]
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    !wr_cfg |=> $stable(cfg_q))
    else $error("config changed without a write");

  AST_CFG_READ: assert property (  // [RL1]
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    rd_en_i && hit_cfg |=> rd_data_o == $past(cfg_q))
    else $error("config read returned wrong value");

  AST_RD_VALID: assert property (  // [RL1]
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    rd_en_i |=> rd_valid_o)
    else $error("read valid missing after read strobe");

  // Read data must stand until the next read
  AST_RD_IDLE: assert property (  // [RL1]
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    !rd_en_i |=> !rd_valid_o && $stable(rd_data_o))
    else $error("read outputs moved without a read");

  AST_EVENT_SET: assert property (  // [RL3]
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    (|event_i) |=> (events_q & $past(event_i)) == $past(event_i))
    else $error("event pulse not captured");

  // A flag may only drop on a read of the event register
  AST_EVENT_STICKY: assert property (  // [RL3]
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    !clr_events |=> (events_q & $past(events_q)) == $past(events_q))
    else $error("event flag lost without a read");

  // A second read with no event in between must find every flag cleared
  AST_EVENT_REREAD_ZERO: assert property (  // [RL3]
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    s_evt_quiet_read ##1 !(|event_i) ##1 clr_events |=> rd_data_o == 8'h00)
    else $error("event flags survived a read");

  AST_RESET_OUTPUTS: assert property (  // [RL7]
    @(posedge clk_sys_i)
    s_reset_release |-> xo_startup_drive_strength_o == TCRB_XO_DRIVE_RESET &&
      battery_low_threshold_select_o == TCRB_BATT_SEL_RESET)
    else $error("config outputs not at reset value");

  AST_RESET_READ: assert property (  // [RL7]
    @(posedge clk_sys_i)
    s_reset_release |-> !rd_valid_o && rd_data_o == 8'h00 && events_q == '0)
    else $error("read side not at reset value");

endmodule

/* bench/tcrb_host_model.sv */
// Host model: issues single-byte register accesses for the bench.
// Assumes the bench calls its tasks; requests change on the falling edge.
`timescale 1ns/1ps
module tcrb_host_model (
  input  wire logic  clk_sys_i, // System clock
  output logic [7:0] addr_o,    // Register address
  output logic       wr_en_o,   // Write strobe
  output logic [7:0] wr_data_o, // Write data
  output logic       rd_en_o    // Read strobe
);
  initial begin
    addr_o    = 8'hFF;
    wr_en_o   = 1'b0;
    wr_data_o = 8'hFF;
    rd_en_o   = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_i);
    addr_o    = a;
    wr_data_o = (a == 8'h00) ? {3'h0, d[4:0]} : d;
    wr_en_o   = 1'b1;
    @(negedge clk_sys_i);
    wr_en_o   = 1'b0;
    wr_data_o = ~wr_data_o;
  endtask

  // Write, then read the same address on the very next edge
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_i);
    addr_o    = a;
    wr_data_o = (a == 8'h00) ? {3'h0, d[4:0]} : d;
    wr_en_o   = 1'b1;
    @(negedge clk_sys_i);
    wr_en_o   = 1'b0;
    rd_en_o   = 1'b1;
    @(negedge clk_sys_i);
    rd_en_o   = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(negedge clk_sys_i);
    addr_o  = a;
    rd_en_o = 1'b1;
    @(negedge clk_sys_i);
    rd_en_o = 1'b0;
    addr_o  = ~addr_o;
  endtask
endmodule

/* bench/tb_transceiver_config_register_bank.sv */
// Testbench for the configuration register bank.
// Assumes the host model drives the strobes; bench drives status and events.
`timescale 1ns/1ps
module tb_transceiver_config_register_bank;
  import tcrb_pkg::*;
  logic       clk_sys_i = 1'b0;
  logic       reset_n_i = 1'b0;
  logic [7:0] status_i  = 8'hA5;
  logic [7:0] event_i   = 8'h00;
  logic [7:0] addr, wr_data, rd_data;
  logic       wr_en, rd_en, rd_valid;
  logic [2:0] drive;
  logic [1:0] thr;
  int         n_fail = 0;
  int         compares = 0;
  int         cycles = 0;

  always #12.5 clk_sys_i = ~clk_sys_i;

  tcrb_host_model HOST (.clk_sys_i(clk_sys_i), .addr_o(addr), .wr_en_o(wr_en),
                        .wr_data_o(wr_data), .rd_en_o(rd_en));
  tcrb_regbank #(.EVENT_W(8)) DUT (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .addr_i(addr), .wr_en_i(wr_en), .wr_data_i(wr_data), .rd_en_i(rd_en),
    .status_i(status_i), .event_i(event_i), .rd_data_o(rd_data), .rd_valid_o(rd_valid),
    .xo_startup_drive_strength_o(drive), .battery_low_threshold_select_o(thr));

  // ==========================================================================
  // Compare and report
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    HOST.rd(a);
    chk({7'h00, rd_valid}, 8'h01);
    chk(rd_data, exp);
  endtask

  task automatic final_report;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 2000) begin
      n_fail++;
      final_report();
    end
  end

  // ==========================================================================
  // Scenarios
  initial begin
    repeat (8) @(negedge clk_sys_i);
    chk({5'h00, drive}, 8'h03);
    chk({6'h00, thr}, 8'h00);
    reset_n_i = 1'b1;
    rd_chk(8'h00, 8'h0C);
    for (int k = 0; k < 4; k++) begin
      HOST.wr(8'h00, {3'h0, 3'(7 - k), 2'(k)});
      chk({5'h00, drive}, 8'(7 - k));
      chk({6'h00, thr}, 8'(k));
      rd_chk(8'h00, 8'(((7 - k) << 2) | k));
    end
    HOST.wr(8'hC0, 8'h5A);
    rd_chk(8'hC0, 8'hA5);
    status_i = 8'h3C;
    rd_chk(8'hC0, 8'h3C);
    rd_chk(8'h00, 8'h13);
    @(negedge clk_sys_i);
    chk({7'h00, rd_valid}, 8'h00);
    chk(rd_data, 8'h13);
    event_i = 8'h81;
    @(negedge clk_sys_i);
    event_i = 8'h00;
    rd_chk(8'hC1, 8'h81);
    rd_chk(8'hC1, 8'h00);
    // An event arriving with the clearing read must survive it
    fork
      rd_chk(8'hC1, 8'h00);
      begin
        @(negedge clk_sys_i);
        event_i = 8'h02;
        @(negedge clk_sys_i);
        event_i = 8'h00;
      end
    join
    rd_chk(8'hC1, 8'h02);
    rd_chk(8'h55, 8'h00);
    HOST.wr_rd(8'h00, 8'h0E);
    chk({7'h00, rd_valid}, 8'h01);
    chk(rd_data, 8'h0E);
    chk({5'h00, drive}, 8'h03);
    chk({6'h00, thr}, 8'h02);
    reset_n_i = 1'b0;
    @(negedge clk_sys_i);
    chk({5'h00, drive}, 8'h03);
    reset_n_i = 1'b1;
    rd_chk(8'h00, 8'h0C);
    final_report();
  end
endmodule
